// *** core/gpio_pkg.sv ***
package gpio_pkg;

   localparam int          DATA_W         = 32;
   localparam int          ADDR_W         = 12;
   localparam int          PINS           = 8;

   // ***********************************************************
   // register word offsets
   // ***********************************************************
   localparam logic [11:0] OFF_OUT_LATCH  = 12'h000;
   localparam logic [11:0] OFF_DIRECTION  = 12'h004;
   localparam logic [11:0] OFF_PIN_INPUT  = 12'h008;
   localparam logic [11:0] OFF_MCU_CTRL   = 12'h00c;
   localparam logic [11:0] OFF_OUT_SET    = 12'h010;
   localparam logic [11:0] OFF_OUT_CLR    = 12'h014;
   localparam logic [11:0] OFF_DIR_SET    = 12'h018;
   localparam logic [11:0] OFF_DIR_CLR    = 12'h01c;

   // ***********************************************************
   // fields and reset values
   // ***********************************************************
   localparam int          PUD_BIT        = 0;
   localparam logic [7:0]  OUT_LATCH_RST  = 8'h00;
   localparam logic [7:0]  DIRECTION_RST  = 8'h00;
   localparam logic [7:0]  PIN_SAMPLE_RST = 8'h00;
   localparam logic        PUD_RST        = 1'b0;

   typedef enum logic [2:0] {
      SEL_OUT,
      SEL_DIR,
      SEL_PIN,
      SEL_CTRL,
      SEL_OUT_SET,
      SEL_OUT_CLR,
      SEL_DIR_SET,
      SEL_DIR_CLR
   } reg_sel_t;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic [7:0] din,
   output logic      [7:0] sample
);

   logic [7:0] latch_q;
   logic [7:0] sample_reg;
   logic [7:0] sample_next;

   // ***********************************************************
   // latch open in the high phase, closes on the falling edge
   // ***********************************************************
   // latch then register
   always_latch begin
      if (pclk && ce) begin
         // non-blocking so the register at the opening edge still sees the held value
         latch_q <= din;
      end
   end

   // the half-cycle latch is what gives the half to one and a half period delay
   // half-period sampling window
   always_comb begin
      sample_next = sample_reg;
      if (ce) begin
         sample_next = latch_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_reg <= gpio_pkg::PIN_SAMPLE_RST;
      end else begin
         sample_reg <= sample_next;
      end
   end

   assign sample = sample_reg;

endmodule

// *** core/pad_drive.sv ***
`timescale 1ns/1ps
module pad_drive (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic [7:0] dir_next,
   input  wire logic [7:0] val_next,
   input  wire logic       pud_next,
   output logic      [7:0] pad_out,
   output logic      [7:0] pad_oe,
   output logic      [7:0] pad_pullup
);

   logic [7:0] out_reg;
   logic [7:0] oe_reg;
   logic [7:0] pu_reg;
   logic [7:0] out_nx;
   logic [7:0] oe_nx;
   logic [7:0] pu_nx;

   // ***********************************************************
   // pad control, registered from the next register values so
   // the pads move on the same edge as the registers
   // ***********************************************************
   always_comb begin
      out_nx = out_reg;
      oe_nx  = oe_reg;
      pu_nx  = pu_reg;
      if (ce) begin
         oe_nx  = dir_next;
         out_nx = val_next;
         pu_nx  = ~dir_next & val_next & {8{~pud_next}};
      end
   end

   // reset clears without a clock edge, so pads float even with pclk stopped
   // async tri-state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg <= gpio_pkg::OUT_LATCH_RST;
         oe_reg  <= gpio_pkg::DIRECTION_RST;
         pu_reg  <= 8'h00;
      end else begin
         out_reg <= out_nx;
         oe_reg  <= oe_nx;
         pu_reg  <= pu_nx;
      end
   end

   assign pad_out    = out_reg;
   assign pad_oe     = oe_reg;
   assign pad_pullup = pu_reg;

endmodule

// *** core/general_purpose_io_port.sv ***
// Notes on behaviour
// - direction bit one makes the pin an output, zero an input
// - input with value bit one gets pull-up unless global pull-up off
// - global pull-up off disables every pull-up, inputs float
// - output pin drives the value bit, pull-up setting ignored
// - reset tri-states every pin at once, no clock needed
// - writing one to a pin input bit toggles its output value bit
// - pin input reads samples, not storage; value and direction are read/write
// - port has separate value, direction and pin input addresses
// - pin input reads the pad whatever the direction
// - synchroniser is a high-transparent latch then a rising-edge register
// - pad change shows in pin input after half to one and a half periods
// - software written value reaches pin input after one period
// - single-bit set or clear touches only the addressed bit
// - alternate use of some pins leaves other pins unchanged
// - deep sleep clamps inputs to ground except kept interrupt pins
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module general_purpose_io_port (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  pad_in,
   output logic      [7:0]  pad_out,
   output logic      [7:0]  pad_oe,
   output logic      [7:0]  pad_pullup,
   input  wire logic        sleep_deep,
   input  wire logic [7:0]  input_keep
);

   // ***********************************************************
   // state
   // ***********************************************************
   logic [7:0]         port_output_latch_reg;
   logic [7:0]         port_output_latch_next;
   logic [7:0]         direction_register_reg;
   logic [7:0]         direction_register_next;
   logic               pullup_global_off_reg;
   logic               pullup_global_off_next;
   logic               pready_reg;
   logic               pready_next;
   logic               pslverr_reg;
   logic               pslverr_next;
   logic [31:0]        prdata_reg;
   logic [31:0]        prdata_next;

   logic [7:0]         pin_input_sample;
   logic [7:0]         pad_gated;
   logic               access;
   logic               commit;
   logic               mapped;
   gpio_pkg::reg_sel_t sel;
   logic [7:0]         wbyte;

   // ***********************************************************
   // address decode
   // ***********************************************************
   // separate addresses per register
   always_comb begin
      mapped = 1'b1;
      sel    = gpio_pkg::SEL_OUT;
      case (paddr)
         gpio_pkg::OFF_OUT_LATCH: sel = gpio_pkg::SEL_OUT;
         gpio_pkg::OFF_DIRECTION: sel = gpio_pkg::SEL_DIR;
         gpio_pkg::OFF_PIN_INPUT: sel = gpio_pkg::SEL_PIN;
         gpio_pkg::OFF_MCU_CTRL:  sel = gpio_pkg::SEL_CTRL;
         gpio_pkg::OFF_OUT_SET:   sel = gpio_pkg::SEL_OUT_SET;
         gpio_pkg::OFF_OUT_CLR:   sel = gpio_pkg::SEL_OUT_CLR;
         gpio_pkg::OFF_DIR_SET:   sel = gpio_pkg::SEL_DIR_SET;
         gpio_pkg::OFF_DIR_CLR:   sel = gpio_pkg::SEL_DIR_CLR;
         default:                 mapped = 1'b0;
      endcase
   end

   // one wait state keeps pready and prdata straight from flops
   assign access = psel && penable && !pready_reg;
   assign commit = psel && penable && pready_reg && pwrite && mapped && pstrb[0];
   assign wbyte  = pwdata[7:0];

   // ***********************************************************
   // register writes
   // ***********************************************************
   always_comb begin
      port_output_latch_next  = port_output_latch_reg;
      direction_register_next = direction_register_reg;
      pullup_global_off_next  = pullup_global_off_reg;
      if (ce && commit) begin
         unique case (sel)
            gpio_pkg::SEL_OUT: begin
               port_output_latch_next = wbyte;
            end
            gpio_pkg::SEL_DIR: begin
               direction_register_next = wbyte;
            end
            gpio_pkg::SEL_PIN: begin
               // xor keeps zeros harmless and ignores direction entirely
               // toggle on one
               port_output_latch_next = port_output_latch_reg ^ wbyte;
            end
            gpio_pkg::SEL_CTRL: begin
               pullup_global_off_next = wbyte[gpio_pkg::PUD_BIT];
            end
            gpio_pkg::SEL_OUT_SET: begin
               port_output_latch_next = port_output_latch_reg | wbyte;
            end
            gpio_pkg::SEL_OUT_CLR: begin
               port_output_latch_next = port_output_latch_reg & ~wbyte;
            end
            gpio_pkg::SEL_DIR_SET: begin
               direction_register_next = direction_register_reg | wbyte;
            end
            gpio_pkg::SEL_DIR_CLR: begin
               direction_register_next = direction_register_reg & ~wbyte;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_output_latch_reg  <= gpio_pkg::OUT_LATCH_RST;
         direction_register_reg <= gpio_pkg::DIRECTION_RST;
         pullup_global_off_reg  <= gpio_pkg::PUD_RST;
      end else begin
         port_output_latch_reg  <= port_output_latch_next;
         direction_register_reg <= direction_register_next;
         pullup_global_off_reg  <= pullup_global_off_next;
      end
   end

   // ***********************************************************
   // bus answer
   // ***********************************************************
   always_comb begin
      pready_next  = pready_reg;
      pslverr_next = pslverr_reg;
      prdata_next  = prdata_reg;
      if (ce) begin
         pready_next  = access;
         pslverr_next = access && !mapped;
         prdata_next  = 32'h0000_0000;
         if (access && !pwrite && mapped) begin
            unique case (sel)
               gpio_pkg::SEL_OUT, gpio_pkg::SEL_OUT_SET, gpio_pkg::SEL_OUT_CLR: begin
                  prdata_next[7:0] = port_output_latch_reg;
               end
               gpio_pkg::SEL_DIR, gpio_pkg::SEL_DIR_SET, gpio_pkg::SEL_DIR_CLR: begin
                  prdata_next[7:0] = direction_register_reg;
               end
               gpio_pkg::SEL_PIN: begin
                  prdata_next[7:0] = pin_input_sample;
               end
               gpio_pkg::SEL_CTRL: begin
                  prdata_next[gpio_pkg::PUD_BIT] = pullup_global_off_reg;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata  = prdata_reg;

   // ***********************************************************
   // pads and input path
   // ***********************************************************
   // each pin is computed bit-wise, so one pin's use never leaks into another
   // pins independent
   pad_drive u_pad_drive (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .dir_next   (direction_register_next),
      .val_next   (port_output_latch_next),
      .pud_next   (pullup_global_off_next),
      .pad_out    (pad_out),
      .pad_oe     (pad_oe),
      .pad_pullup (pad_pullup)
   );

   // clamp ahead of the synchroniser; floating pads in sleep would burn current
   // sleep clamp to ground
   assign pad_gated = pad_in & ~({8{sleep_deep}} & ~input_keep);

   // a driven value appears on pad_out on the same edge as the write, the latch
   // opens in that high phase, so pin input follows one period later
   // one-period readback
   pin_sync u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .din     (pad_gated),
      .sample  (pin_input_sample)
   );

endmodule

// *** tb/gpio_port_props.sv ***
`timescale 1ns/1ps
// ****************************************
// port-level checker
// ****************************************
module gpio_port_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pad_pullup
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   assign wr = psel & penable & pready & pwrite & pstrb[0] & !pslverr;
   // global pull-up off as last written over the bus
   logic pud_seen;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pud_seen <= gpio_pkg::PUD_RST;
      end else if (wr && paddr == gpio_pkg::OFF_MCU_CTRL) begin
         pud_seen <= pwdata[gpio_pkg::PUD_BIT];
      end
   end
   rst_quiet_a: assert property ($rose(presetn) |-> pad_oe == 8'h00
      && pad_pullup == 8'h00) else $error("pads not quiet after reset");
   dir_write_a: assert property (wr && paddr == gpio_pkg::OFF_DIRECTION
      |=> pad_oe == $past(pwdata[7:0])) else $error("direction write lost");
   drive_value_a: assert property (wr && paddr == gpio_pkg::OFF_OUT_LATCH
      |=> (pad_out & pad_oe) == ($past(pwdata[7:0]) & pad_oe))
      else $error("driven value wrong");
   toggle_out_a: assert property (wr && paddr == gpio_pkg::OFF_PIN_INPUT
      |=> ((pad_out ^ $past(pad_out)) & pad_oe) == ($past(pwdata[7:0]) & pad_oe))
      else $error("toggle wrong");
   dir_set_a: assert property (wr && paddr == gpio_pkg::OFF_DIR_SET
      |=> pad_oe == ($past(pad_oe) | $past(pwdata[7:0]))) else $error("set wrong");
   dir_clr_a: assert property (wr && paddr == gpio_pkg::OFF_DIR_CLR
      |=> pad_oe == ($past(pad_oe) & ~$past(pwdata[7:0]))) else $error("clear wrong");
   pull_input_a: assert property (pad_pullup == (~pad_oe & pad_out & {8{~pud_seen}}))
      else $error("pull-up does not follow direction and value");
   pud_off_a: assert property (wr && paddr == gpio_pkg::OFF_MCU_CTRL && pwdata[0]
      |=> pad_pullup == 8'h00) else $error("pull-up left on");
   ready_pulse_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single pulse");
   bad_addr_a: assert property (pready && paddr > 12'h01c |-> pslverr)
      else $error("unmapped address accepted");
   cover property (wr && paddr == gpio_pkg::OFF_PIN_INPUT);
   cover property (wr && paddr == gpio_pkg::OFF_MCU_CTRL && pwdata[0]);
   cover property (pslverr);
endmodule

bind general_purpose_io_port gpio_port_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .pad_out, .pad_oe, .pad_pullup);

// *** tb/pad_world.sv ***
`timescale 1ns/1ps
// ****************************************
// board side of the pads
// ****************************************
module pad_world (
   input  wire logic       pclk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pad_pullup,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pad_in
);
   logic [7:0] churn = 8'h5a;
   // a floating pin shows a changing pattern, never a stable guess
   always @(posedge pclk) churn <= ~churn;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pad_pullup[i]) pad_in[i] = 1'h1;
         else pad_in[i] = churn[i];
      end
   end
endmodule

// *** tb/general_purpose_io_port_tb.sv ***
`timescale 1ns/1ps
module general_purpose_io_port_tb;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pad_in;
   logic [7:0]  pad_out;
   logic [7:0]  pad_oe;
   logic [7:0]  pad_pullup;
   logic        sleep_deep = 1'h0;
   logic [7:0]  input_keep = 8'h00;
   logic [7:0]  ext_val = 8'h00;
   logic [7:0]  ext_en = 8'hff;
   logic [31:0] rd;
   logic        err;
   logic [11:0] offs [9];
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          m_dir, m_out, m_pud, op, d, s, lvl;

   always #25 pclk = ~pclk;

   general_purpose_io_port u_general_purpose_io_port (.pclk(pclk), .presetn(presetn),
      .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .sleep_deep(sleep_deep), .input_keep(input_keep));
   pad_world u_pad_world (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] v,
                      input logic sb);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      pstrb   <= {3'h0, sb};
      @(posedge pclk);
      penable <= 1'h1;
      // only the bench timeout ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic pads();
      cmp({24'h0, pad_oe}, m_dir);
      cmp({24'h0, pad_out & pad_oe}, m_out & m_dir);
      cmp({24'h0, pad_pullup}, ~m_dir & m_out & (m_pud ? 0 : 255));
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      offs = '{gpio_pkg::OFF_OUT_LATCH, gpio_pkg::OFF_DIRECTION, gpio_pkg::OFF_PIN_INPUT,
               gpio_pkg::OFF_MCU_CTRL, gpio_pkg::OFF_OUT_SET, gpio_pkg::OFF_OUT_CLR,
               gpio_pkg::OFF_DIR_SET, gpio_pkg::OFF_DIR_CLR, 12'h100};
      void'($urandom(32'h32a773a7));
      m_dir = 0;
      m_out = 0;
      m_pud = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      pads();
      for (int i = 0; i < 60; i++) begin
         op = (i < 9) ? i : $urandom_range(8);
         d  = $urandom_range(255);
         s  = (i < 9) || ($urandom_range(3) != 0);
         // one register per write, so no pin skips an intermediate state
         apb(offs[op], 1'h1, d, s[0]);
         cmp(err, op == 8);
         if (s != 0) begin
            case (op)
               0: m_out = d;
               1: m_dir = d;
               2: m_out ^= d;
               3: m_pud = d & 1;
               4: m_out |= d;
               5: m_out &= ~d & 255;
               6: m_dir |= d;
               7: m_dir &= ~d & 255;
               default: ;
            endcase
         end
         pads();
         ext_en     <= ~m_dir[7:0];
         ext_val    <= 8'($urandom_range(255));
         sleep_deep <= (i >= 40);
         input_keep <= 8'($urandom_range(255));
         @(posedge pclk);
         lvl = (m_dir & m_out | ~m_dir & ext_val) & (sleep_deep ? input_keep : 255);
         apb(gpio_pkg::OFF_PIN_INPUT, 1'h0, 0, 1'h1);
         cmp(rd, lvl);
         apb(gpio_pkg::OFF_OUT_LATCH, 1'h0, 0, 1'h1);
         cmp(rd, m_out);
         apb(gpio_pkg::OFF_DIRECTION, 1'h0, 0, 1'h1);
         cmp(rd, m_dir);
         apb(gpio_pkg::OFF_MCU_CTRL, 1'h0, 0, 1'h1);
         cmp(rd, m_pud);
         if (i == 30) begin
            @(negedge pclk);
            presetn = 1'h0;
            #1;
            cmp({pad_oe, pad_pullup}, 0);
            m_dir = 0;
            m_out = 0;
            m_pud = 0;
            @(posedge pclk);
            presetn <= 1'h1;
            @(posedge pclk);
         end
      end
      wrap_up();
   end
endmodule
